/* File: coproc_model.sv */
`timescale 1ns/1ns
// ==========================================================
// Coprocessor stand-in: asks for memory work, takes outcomes
// ==========================================================
module coproc_model
    import offload_mem_pkg::*;
(
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    output logic                                mem_req_valid,
    input  wire logic                           mem_req_ready,
    output logic [offload_mem_pkg::REQ_WIDTH-1:0]  mem_req_packet,
    input  wire logic                           outcome_valid,
    input  wire logic [offload_mem_pkg::OUT_WIDTH-1:0] outcome_packet,
    output logic                                wb_valid,
    input  wire logic                           wb_ready,
    output logic [offload_mem_pkg::ID_WIDTH-1:0]   wb_id,
    output logic [offload_mem_pkg::DATA_WIDTH-1:0] wb_data,
    output logic [offload_mem_pkg::REG_WIDTH-1:0]  wb_rd,
    output logic                                wb_exc
);
    // Outcomes seen, oldest first
    logic [OUT_WIDTH-1:0] got_q[$];

    // Quiet lines at time zero
    initial begin
        mem_req_valid  = 1'b0;
        mem_req_packet = '0;
        wb_valid       = 1'b0;
        {wb_id, wb_data, wb_rd, wb_exc} = '0;
    end

    // No ready on this channel, so every valid cycle is taken
    always @(posedge clk_sys) begin
        if (rst_n && outcome_valid) begin
            got_q.push_back(outcome_packet);
        end
    end

    // Raise a request and hold it until taken; caller releases
    task automatic send_req(input logic [REQ_WIDTH-1:0] p);
        int k;
        @(negedge clk_sys);
        mem_req_valid  = 1'b1;
        mem_req_packet = p;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (mem_req_ready) break;
        end
    endtask : send_req

    // Drop the request; packet turns to a changed pattern
    task automatic idle_req();
        @(negedge clk_sys);
        mem_req_valid  = 1'b0;
        mem_req_packet = ~mem_req_packet;
    endtask : idle_req

    // Offer a writeback, held until the core takes it
    task automatic send_wb(input logic [3:0] id, input logic [31:0] d,
                           input logic [4:0] rd, input logic exc);
        int k;
        @(negedge clk_sys);
        wb_valid = 1'b1;
        {wb_id, wb_data, wb_rd, wb_exc} = {id, d, rd, exc};
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (wb_ready) break;
        end
    endtask : send_wb

    // Release writeback; stale fields are inverted, not kept
    task automatic idle_wb();
        @(negedge clk_sys);
        wb_valid = 1'b0;
        {wb_id, wb_data, wb_rd, wb_exc} = ~{wb_id, wb_data, wb_rd, wb_exc};
    endtask : idle_wb
endmodule : coproc_model

/* File: offload_mem_pkg.sv */
package offload_mem_pkg;

    // ========================================================
    // Packet widths (shared by core and coprocessor builds)
    // ========================================================
    localparam int unsigned ID_WIDTH    = 4;   // Instruction id width
    localparam int unsigned ADDR_WIDTH  = 32;  // Memory address width
    localparam int unsigned DATA_WIDTH  = 32;  // Memory data width
    localparam int unsigned REG_WIDTH   = 5;   // Destination register idx
    localparam int unsigned FIFO_DEPTH  = 8;   // Outcome queue depth
    localparam int unsigned MEM_LATENCY = 2;   // Cycles from accept to data

    // Request packet: id, write flag, byte enables, address, write data
    localparam int unsigned REQ_WIDTH =
        ID_WIDTH + 1 + 4 + ADDR_WIDTH + DATA_WIDTH;

    // Outcome packet: id, error flag, read data
    localparam int unsigned OUT_WIDTH = ID_WIDTH + 1 + DATA_WIDTH;

    // ========================================================
    // Reset values and attribute window
    // ========================================================
    localparam logic [ADDR_WIDTH-1:0] ATTR_BASE  = 32'h0000_0000;
    localparam logic [ADDR_WIDTH-1:0] ATTR_LIMIT = 32'h7fff_ffff;
    localparam logic [1:0]            LAT_RESET  = 2'h0;

    // ========================================================
    // Memory sequencer states
    // ========================================================
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,   // Waiting for a request
        SEQ_WAIT = 2'b01,   // Memory access in flight
        SEQ_DONE = 2'b11    // Outcome ready to queue
    } seq_state_e;

    // Attribute check: address inside allowed window, word aligned
    function automatic logic attr_ok(input logic [ADDR_WIDTH-1:0] a);
        attr_ok = (a >= ATTR_BASE) && (a <= ATTR_LIMIT) && (a[1:0] == 2'h0);
    endfunction : attr_ok

endpackage : offload_mem_pkg

/* File: offload_memory_result_port.sv */
`timescale 1ns/1ns
// Summary of operation
// - Request taken only when valid and ready
// - Check response per accepted request, no data
// - Outcome valid with packet when result held
// - Writeback taken only when valid and ready
// - All ends built with identical parameter values
// - Timing split 20/20/60 core, interconnect, coprocessor
module offload_memory_result_port
    import offload_mem_pkg::*;
(
    input  wire logic                                clk_sys,
    input  wire logic                                rst_n,
    // Memory request channel
    input  wire logic                                mem_req_valid,
    output logic                                     mem_req_ready,
    input  wire logic [offload_mem_pkg::REQ_WIDTH-1:0] mem_req_packet,
    output logic                                     mem_rsp_valid,
    output logic                                     mem_rsp_exc,
    output logic      [offload_mem_pkg::ID_WIDTH-1:0]  mem_rsp_id,
    // Core memory access port
    output logic                                     core_mem_req,
    output logic                                     core_mem_we,
    output logic      [3:0]                          core_mem_be,
    output logic      [offload_mem_pkg::ADDR_WIDTH-1:0] core_mem_addr,
    output logic      [offload_mem_pkg::DATA_WIDTH-1:0] core_mem_wdata,
    input  wire logic [offload_mem_pkg::DATA_WIDTH-1:0] core_mem_rdata,
    input  wire logic                                core_mem_err,
    // Outcome channel, no ready
    output logic                                     outcome_valid,
    output logic      [offload_mem_pkg::OUT_WIDTH-1:0] outcome_packet,
    // Writeback channel
    input  wire logic                                wb_valid,
    output logic                                     wb_ready,
    input  wire logic [offload_mem_pkg::ID_WIDTH-1:0]  wb_id,
    input  wire logic [offload_mem_pkg::DATA_WIDTH-1:0] wb_data,
    input  wire logic [offload_mem_pkg::REG_WIDTH-1:0] wb_rd,
    input  wire logic                                wb_exc,
    input  wire logic                                wb_stall,
    // Register file write port
    output logic                                     rf_we,
    output logic      [offload_mem_pkg::REG_WIDTH-1:0] rf_waddr,
    output logic      [offload_mem_pkg::DATA_WIDTH-1:0] rf_wdata,
    output logic                                     wb_exc_pulse
);
    import offload_mem_pkg::*;   // Shared widths for every end

    // ========================================================
    // Request fields
    // ========================================================
    logic [ID_WIDTH-1:0]   req_id;     // Request instruction id
    logic                  req_we;     // Store when set
    logic [3:0]            req_be;     // Byte enables
    logic [ADDR_WIDTH-1:0] req_addr;   // Target address
    logic [DATA_WIDTH-1:0] req_wdata;  // Store data
    logic                  req_fire;   // Request handshake
    logic                  req_ok;     // Attribute check passed

    assign {req_id, req_we, req_be, req_addr, req_wdata} = mem_req_packet;
    assign req_fire = mem_req_valid && mem_req_ready;
    assign req_ok   = attr_ok(req_addr);

    // ========================================================
    // Sequencer state
    // ========================================================
    seq_state_e            state_q;     // Sequencer state
    logic [1:0]            lat_q;       // Access latency counter
    logic [ID_WIDTH-1:0]   id_q;        // Id of access in flight
    logic                  err_q;       // Access failed check or bus
    logic [DATA_WIDTH-1:0] rdata_q;     // Captured read data
    logic                  fifo_ready;  // Outcome queue has room
    logic                  out_push;    // Outcome enters queue

    // One access at a time, and only while the outcome queue has room:
    // this is how back-pressure from the queue reaches the coprocessor.
    assign mem_req_ready = (state_q == SEQ_IDLE) && fifo_ready;
    assign out_push      = (state_q == SEQ_DONE);

    // State sequencing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SEQ_IDLE;
        end else begin
            unique case (state_q)
                SEQ_IDLE: begin
                    if (req_fire) begin
                        // Failed check skips the memory access
                        state_q <= req_ok ? SEQ_WAIT : SEQ_DONE;
                    end
                end
                SEQ_WAIT: begin
                    if (lat_q == 2'(MEM_LATENCY - 1)) begin
                        state_q <= SEQ_DONE;
                    end
                end
                SEQ_DONE: begin
                    // Queue room was reserved at accept time
                    state_q <= SEQ_IDLE;
                end
                default: begin
                    // Illegal code recovers to idle
                    state_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Latency counter while the access is in flight
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lat_q <= LAT_RESET;
        end else if (state_q == SEQ_WAIT) begin
            lat_q <= lat_q + 2'h1;
        end else begin
            lat_q <= LAT_RESET;
        end
    end

    // Core memory port drive, held for the whole access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_mem_req   <= 1'b0;
            core_mem_we    <= 1'b0;
            core_mem_be    <= 4'h0;
            core_mem_addr  <= '0;
            core_mem_wdata <= '0;
        end else if (req_fire && req_ok) begin
            core_mem_req   <= 1'b1;
            core_mem_we    <= req_we;
            core_mem_be    <= req_be;
            core_mem_addr  <= req_addr;
            core_mem_wdata <= req_wdata;
        end else if (state_q == SEQ_WAIT &&
                     lat_q == 2'(MEM_LATENCY - 1)) begin
            core_mem_req <= 1'b0;
        end
    end

    // Outcome capture: id, error and read data
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            id_q    <= '0;
            err_q   <= 1'b0;
            rdata_q <= '0;
        end else if (req_fire) begin
            id_q    <= req_id;
            err_q   <= !req_ok;
            rdata_q <= '0;
        end else if (state_q == SEQ_WAIT &&
                     lat_q == 2'(MEM_LATENCY - 1)) begin
            err_q   <= core_mem_err;
            rdata_q <= core_mem_we ? '0 : core_mem_rdata;
        end
    end

    // ========================================================
    // Check response, one cycle after accept
    // ========================================================
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem_rsp_valid <= 1'b0;
            mem_rsp_exc   <= 1'b0;
            mem_rsp_id    <= '0;
        end else begin
            mem_rsp_valid <= req_fire;
            mem_rsp_exc   <= req_fire && !req_ok;
            if (req_fire) begin
                mem_rsp_id <= req_id;
            end
        end
    end

    // ========================================================
    // Outcome queue; drains every cycle since the far end never stalls
    // ========================================================
    logic                 q_valid;
    logic [OUT_WIDTH-1:0] q_data;

    outcome_fifo #(
        .WIDTH (OUT_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) outcome_fifo_inst (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (out_push),
        .in_ready  (fifo_ready),
        .in_data   ({id_q, err_q, rdata_q}),
        .out_valid (q_valid),
        .out_ready (1'b1),
        .out_data  (q_data)
    );

    // Outcome registered: shown for exactly one cycle per word
    // Flops on the outputs keep the core's share of the path small,
    // leaving most of the cycle to the coprocessor
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            outcome_valid  <= 1'b0;
            outcome_packet <= '0;
        end else begin
            outcome_valid <= q_valid;
            if (q_valid) begin
                outcome_packet <= q_data;
            end
        end
    end

    // ========================================================
    // Writeback channel into the register file
    // ========================================================
    logic wb_fire;

    // Stall input lets the pipeline refuse writebacks
    assign wb_ready = !wb_stall;
    assign wb_fire  = wb_valid && wb_ready;

    // Register file write, one cycle per accepted writeback with no exception and wb_rd not zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rf_we        <= 1'b0;
            rf_waddr     <= '0;
            rf_wdata     <= '0;
            wb_exc_pulse <= 1'b0;
        end else begin
            // Exceptions never write the register file
            rf_we        <= wb_fire && !wb_exc && (wb_rd != '0);
            wb_exc_pulse <= wb_fire && wb_exc;
            if (wb_fire) begin
                rf_waddr <= wb_rd;
                rf_wdata <= wb_data;
            end
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    a_req_take_resp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req_fire |=> mem_rsp_valid && mem_rsp_id == $past(req_id))
        else $error("no check response after accepted request");
    a_rsp_only_fire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mem_rsp_valid |-> $past(mem_req_valid && mem_req_ready))
        else $error("response without handshake");
    a_outcome_follows: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req_fire && req_ok) |-> ##[3:14] outcome_valid)
        else $error("outcome missing after good request");
    a_outcome_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        outcome_valid |-> $past(q_valid))
        else $error("outcome without queued word");
    a_wb_write_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rf_we |-> $past(wb_valid) && $past(wb_ready)
                  && rf_waddr == $past(wb_rd))
        else $error("register write without writeback handshake");
    a_wb_stall_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wb_stall |=> !rf_we && !wb_exc_pulse)
        else $error("writeback taken while stalled");
    a_busy_not_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
        req_fire |=> !mem_req_ready)
        else $error("second request taken while busy");
    a_bad_addr_err: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (req_fire && !req_ok) |=> mem_rsp_exc && out_push && err_q)
        else $error("failed check not reported");
    c_load_outcome: cover property (@(posedge clk_sys) disable iff (!rst_n)
        req_fire && req_ok && !req_we ##[1:12] outcome_valid);
    c_bad_request: cover property (@(posedge clk_sys) disable iff (!rst_n)
        mem_rsp_exc);
    c_wb_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rf_we);
    c_wb_exc: cover property (@(posedge clk_sys) disable iff (!rst_n)
        wb_exc_pulse);

endmodule : offload_memory_result_port

/* File: offload_memory_result_port_tb_top.sv */
`timescale 1ns/1ns
// ==========================================================
// Bench for the offload memory and writeback port
// ==========================================================
module offload_memory_result_port_tb_top;
    import offload_mem_pkg::*;

    localparam logic [31:0] RD_MASK  = 32'h5a5a_0000; // Load data pattern
    localparam logic [31:0] ERR_ADDR = 32'h0000_0f00; // Memory faults here
    localparam int          LIMIT    = 3000;          // Whole run ceiling

    logic                  clk_sys, rst_n, wb_stall;
    logic                  mem_req_valid, mem_req_ready;
    logic [REQ_WIDTH-1:0]  mem_req_packet;
    logic                  mem_rsp_valid, mem_rsp_exc;
    logic [ID_WIDTH-1:0]   mem_rsp_id, wb_id;
    logic                  core_mem_req, core_mem_we, core_mem_err;
    logic [3:0]            core_mem_be;
    logic [ADDR_WIDTH-1:0] core_mem_addr;
    logic [DATA_WIDTH-1:0] core_mem_wdata, core_mem_rdata, wb_data, rf_wdata;
    logic                  outcome_valid, wb_valid, wb_ready, wb_exc;
    logic [OUT_WIDTH-1:0]  outcome_packet;
    logic [REG_WIDTH-1:0]  wb_rd, rf_waddr;
    logic                  rf_we, wb_exc_pulse;
    // Bookkeeping; queues hold expected and observed results
    int                    n_mismatch, checks_done, cyc, n_sent, n_acc, n_exc;
    logic [63:0]           exp_out[$], exp_rsp[$], rsp_q[$], rf_q[$];

    offload_memory_result_port offload_memory_result_port_inst (
        .clk_sys, .rst_n, .mem_req_valid, .mem_req_ready, .mem_req_packet,
        .mem_rsp_valid, .mem_rsp_exc, .mem_rsp_id, .core_mem_req,
        .core_mem_we, .core_mem_be, .core_mem_addr, .core_mem_wdata,
        .core_mem_rdata, .core_mem_err, .outcome_valid, .outcome_packet,
        .wb_valid, .wb_ready, .wb_id, .wb_data, .wb_rd, .wb_exc, .wb_stall,
        .rf_we, .rf_waddr, .rf_wdata, .wb_exc_pulse);

    coproc_model coproc_model_inst (
        .clk_sys, .rst_n, .mem_req_valid, .mem_req_ready, .mem_req_packet,
        .outcome_valid, .outcome_packet, .wb_valid, .wb_ready, .wb_id,
        .wb_data, .wb_rd, .wb_exc);

    // ======================================================
    // Clock, memory behind the core, monitors
    // ======================================================
    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;

    // Memory answers during access; otherwise data keeps changing
    always @(negedge clk_sys) begin
        core_mem_rdata <= core_mem_req ? (core_mem_addr ^ RD_MASK)
                                       : ~core_mem_rdata;
        core_mem_err   <= core_mem_req && (core_mem_addr == ERR_ADDR);
    end

    // Record handshakes and pulses; cut a hang short
    always @(posedge clk_sys) begin
        cyc++;
        if (mem_req_valid && mem_req_ready) n_acc++;
        if (mem_rsp_valid) rsp_q.push_back(64'({mem_rsp_exc, mem_rsp_id}));
        if (rf_we) rf_q.push_back(64'({rf_waddr, rf_wdata}));
        if (wb_exc_pulse) n_exc++;
        // Core port carries the packet fields; only 0x104 is a store
        if (core_mem_req)
            chk_pkt("mem port",
                    64'({(core_mem_addr == 32'h0000_0104), 4'hf,
                         ~core_mem_addr}),
                    64'({core_mem_we, core_mem_be,
                         core_mem_wdata}));
        if (cyc == LIMIT) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ======================================================
    // Compare and closing tasks
    // ======================================================
    task automatic chk_pkt(input string nm, input logic [63:0] e,
                           input logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk_pkt

    task automatic chk_cnt(input string nm, input int e, input int g);
        checks_done++;
        if (g != e) begin
            n_mismatch++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_cnt

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // ======================================================
    // Request helpers: expectation worked out from address
    // ======================================================
    task automatic req(input logic [3:0] id, input logic we,
                       input logic [31:0] a);
        logic        bad;
        logic        err;
        logic [31:0] rd;
        bad = (a > ATTR_LIMIT) || (a[1:0] != 2'h0);
        err = bad || (a == ERR_ADDR);
        // A bus fault still hands back what the memory returned
        rd  = (bad || we) ? 32'h0 : (a ^ RD_MASK);
        exp_rsp.push_back(64'({bad, id}));
        exp_out.push_back(64'({id, err, rd}));
        n_sent++;
        coproc_model_inst.send_req({id, we, 4'hf, a, ~a});
    endtask : req

    // Release, wait for all outcomes, then judge in order
    task automatic drain(input string nm);
        int k;
        coproc_model_inst.idle_req();
        for (k = 0; k < 40; k++) begin
            if (coproc_model_inst.got_q.size() >= exp_out.size()) break;
            @(posedge clk_sys);
        end
        repeat (3) @(posedge clk_sys); // Room for a stray extra
        chk_cnt("accepts", n_sent, n_acc);
        chk_cnt("replies", exp_rsp.size(), rsp_q.size());
        chk_cnt("outcomes", exp_out.size(),
                coproc_model_inst.got_q.size());
        while (exp_out.size() > 0 && coproc_model_inst.got_q.size() > 0)
            chk_pkt("outcome", exp_out.pop_front(),
                    64'(coproc_model_inst.got_q.pop_front()));
        while (exp_rsp.size() > 0 && rsp_q.size() > 0)
            chk_pkt("reply", exp_rsp.pop_front(), rsp_q.pop_front());
        exp_out.delete();
        exp_rsp.delete();
        rsp_q.delete();
        coproc_model_inst.got_q.delete();
        n_sent = 0;
        n_acc = 0;
        $display("test %s done", nm);
    endtask : drain

    // ======================================================
    // Scenarios
    // ======================================================
    task automatic t_single();
        req(4'h3, 1'b0, 32'h0000_0100);
        drain("single load");
    endtask : t_single

    // Back-to-back mix: store, misaligned, outside, fault, edge
    task automatic t_mix();
        logic [31:0] a [6];
        int          k;
        a = '{32'h104, 32'h102, 32'h8000_0000, ERR_ADDR, 32'h7fff_fffc,
              32'h200};
        for (k = 0; k < 6; k++) begin
            req(4'(k + 8), 1'(k == 0), a[k]);
        end
        drain("mixed burst");
    endtask : t_mix

    // Writeback offered under stall must wait for ready
    task automatic t_wb_stall();
        @(negedge clk_sys);
        wb_stall = 1'b1;
        fork
            begin
                coproc_model_inst.send_wb(4'h1, 32'hcafe_0001, 5'h07, 1'b0);
                coproc_model_inst.idle_wb();
            end
            begin
                repeat (4) @(posedge clk_sys);
                chk_cnt("stalled writes", 0, rf_q.size());
                @(negedge clk_sys);
                wb_stall = 1'b0;
            end
        join
        repeat (2) @(posedge clk_sys);
        chk_cnt("writes", 1, rf_q.size());
        chk_pkt("rf write", 64'({5'h07, 32'hcafe_0001}),
                rf_q.pop_front());
        $display("test writeback stall done");
    endtask : t_wb_stall

    // Every-cycle writebacks: two writes, one to x0, one fault
    task automatic t_wb_burst();
        n_exc = 0;
        coproc_model_inst.send_wb(4'h2, 32'h1111_0000, 5'h01, 1'b0);
        coproc_model_inst.send_wb(4'h3, 32'h2222_0000, 5'h02, 1'b0);
        coproc_model_inst.send_wb(4'h4, 32'h3333_0000, 5'h00, 1'b0);
        coproc_model_inst.send_wb(4'h5, 32'h4444_0000, 5'h03, 1'b1);
        coproc_model_inst.idle_wb();
        repeat (3) @(posedge clk_sys);
        chk_cnt("burst writes", 2, rf_q.size());
        chk_pkt("write one", 64'({5'h01, 32'h1111_0000}),
                rf_q.pop_front());
        chk_pkt("write two", 64'({5'h02, 32'h2222_0000}),
                rf_q.pop_front());
        chk_cnt("exceptions", 1, n_exc);
        $display("test writeback burst done");
    endtask : t_wb_burst

    // Main sequence; reset held three cycles
    initial begin
        rst_n          = 1'b0;
        wb_stall       = 1'b0;
        core_mem_rdata = '0;
        core_mem_err   = 1'b0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        chk_pkt("idle outs", 64'h8, 64'({mem_req_ready, outcome_valid,
                mem_rsp_valid, rf_we}));
        t_single();
        t_mix();
        t_wb_stall();
        t_wb_burst();
        end_sim();
    end
endmodule : offload_memory_result_port_tb_top

/* File: outcome_fifo.sv */
`timescale 1ns/1ns
module outcome_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // ========================================================
    // Storage and pointers
    // ========================================================
    logic [WIDTH-1:0] mem_q [DEPTH];   // Word storage
    logic [AW-1:0]    wr_q;            // Write pointer
    logic [AW-1:0]    rd_q;            // Read pointer
    logic [AW:0]      cnt_q;           // Words held
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));   // Honest full
    assign out_valid = (cnt_q != '0);               // Honest empty
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    // Data array: no reset needed, guarded by count
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ========================================================
    // Checks
    // ========================================================
    a_no_overflow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
    a_pop_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pop && !push) |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("fifo count not reduced on pop");
    c_fifo_pop: cover property (@(posedge clk_sys) disable iff (!rst_n)
        pop);

endmodule : outcome_fifo
